// ---- common/scan_test_defs.vh ----
`ifndef SCAN_TEST_DEFS_VH
`define SCAN_TEST_DEFS_VH
// TAP state codes
`define TAP_RESET      4'h0
`define TAP_IDLE       4'h1
`define TAP_SEL_DR     4'h2
`define TAP_CAP_DR     4'h3
`define TAP_SHIFT_DR   4'h4
`define TAP_EXIT1_DR   4'h5
`define TAP_PAUSE_DR   4'h6
`define TAP_EXIT2_DR   4'h7
`define TAP_UPD_DR     4'h8
`define TAP_SEL_IR     4'h9
`define TAP_CAP_IR     4'ha
`define TAP_SHIFT_IR   4'hb
`define TAP_EXIT1_IR   4'hc
`define TAP_PAUSE_IR   4'hd
`define TAP_EXIT2_IR   4'he
`define TAP_UPD_IR     4'hf
// Instruction values
`define IR_CAPTURE     8'h81
`define IR_RESET       8'hff
`define OP_EXTEST      8'h00
`define OP_SAMPLE      8'h82
`define OP_INTEST      8'h03
`define OP_HIGHZ       8'h06
`define OP_CLAMP       8'h87
`define OP_BOUNDARY_RUN_TEST        8'h09
`define OP_READN       8'h0a
`define OP_READT       8'h8b
`define OP_SELFCHK     8'h0c
`define OP_TOGGLE      8'h8d
`define OP_CTLN        8'h8e
`define OP_CTLT        8'h0f
// Selected data register
`define SEL_BYPASS     2'h0
`define SEL_PINS       2'h1
`define SEL_CTL        2'h2
// Chain resets and field positions
`define PIN_RESET      36'h000000000
`define CTL_RESET      11'h002
`define PIN_BEN        35
`define PIN_AEN        34
`define PIN_FLOW       33
`define PIN_OEN        32
`define PIN_BIN_LO     24
`define PIN_BOUT_LO    16
`define PIN_AIN_LO     8
`define PIN_AOUT_LO    0
`define CTL_MASK_LO    3
`endif

// ---- hw/scan_test_port.v ----
// Operation
// - Shift-IR puts IR on TDO; TDO enables on first falling edge, showing IR bit 0.
// - IR shifts each rising edge in Shift-IR, including the exiting edge, not entry.
// - Exit2-IR returns to Shift-IR without recapture; TDO floats after Exit1-IR.
// - Pause-IR does nothing and holds the partial IR contents.
// - Update-IR falling edge loads shadow instruction and mode.
// - Test registers are shift stage plus shadow; capture, shift, update.
// - IR is eight bits; bit 7 is even parity supplied by controller.
// - Capture-IR loads 10000001.
// - Reset forces active instruction to 11111111, bypass.
// - Pin-cell chain is 36 bits, resets to zero.
// - Enable cells capture not oe_n and flow, or not flow.
// - Pin chain order TDI, bits 35 to 0, TDO, with fixed field map.
// - Control chain is 11 bits, unchanged at Capture-DR, resets to 00000000010.
// - Control chain scans bit 10 to 0; exclusion bits 10-3, operation 2-0.
// - Bypass is one stage without shadow, captures zero.
// - EXTEST and INTEST select pin chain in test mode.
// - SAMPLE/PRELOAD selects pin chain in normal mode.
// - HIGHZ selects bypass, modified test; CLAMP selects bypass, test.
// - boundary_run_test and output_toggle_test select bypass in test mode.
// - Read-normal, read-testmode, self-check select pin chain; normal, test, normal.
// - Control scan opcodes select control chain; normal and test respectively.
// - Unlisted and unassigned opcodes execute bypass in normal mode.
// - Capture on TCK rising edges, change outputs on TCK falling edges.
// - Capture-IR load happens on the rising edge leaving Capture-IR.
`timescale 1ns/100ps
`default_nettype none
`include "scan_test_defs.vh"
module scan_test_port (
  input  wire        clk,
  input  wire        rst,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo,
  output reg         tdoOe_n,
  input  wire        output_enable_n,
  input  wire        flow_select,
  input  wire [7:0]  a_port_lines,
  input  wire [7:0]  b_port_lines,
  input  wire [7:0]  coreAOut,
  input  wire [7:0]  coreBOut,
  output reg  [7:0]  activeInstruction,
  output reg  [1:0]  selectedChain,
  output reg         testMode,
  output reg         modifiedTestMode,
  output reg  [35:0] pinShadow,
  output reg  [10:0] ctlShadow,
  output reg  [3:0]  tapState
);

  // Instruction decode: selected chain, test mode, modified test mode
  function [3:0] decode;
    input [7:0] op;
    begin
      case (op)
        `OP_EXTEST, `OP_INTEST: decode = {`SEL_PINS, 2'b10};
        `OP_SAMPLE:             decode = {`SEL_PINS, 2'b00};
        `OP_HIGHZ:              decode = {`SEL_BYPASS, 2'b11};
        `OP_CLAMP:              decode = {`SEL_BYPASS, 2'b10};
        `OP_BOUNDARY_RUN_TEST, `OP_TOGGLE:   decode = {`SEL_BYPASS, 2'b10};
        `OP_READN, `OP_SELFCHK: decode = {`SEL_PINS, 2'b00};
        `OP_READT:              decode = {`SEL_PINS, 2'b10};
        `OP_CTLN:               decode = {`SEL_CTL, 2'b00};
        `OP_CTLT:               decode = {`SEL_CTL, 2'b10};
        default:                decode = {`SEL_BYPASS, 2'b00};
      endcase
    end
  endfunction

  // Pin inputs pass two flops; tck edges are found from the synchronised copy
  reg [1:0] tckSync;
  reg [1:0] tmsSync;
  reg [1:0] tdiSync;
  reg       tckLast;
  always @(posedge clk) begin
    tckSync <= {tckSync[0], tck};
    tmsSync <= {tmsSync[0], tms};
    tdiSync <= {tdiSync[0], tdi};
    tckLast <= tckSync[1];
  end
  wire tckRise = tckSync[1] & ~tckLast;
  wire tckFall = ~tckSync[1] & tckLast;
  wire tmsS    = tmsSync[1];
  wire tdiS    = tdiSync[1];

  reg [3:0]  next_tapState;
  reg [7:0]  irShift;
  reg [35:0] pinShift;
  reg [10:0] ctlShift;
  reg        bypassBit;

  always @* begin
    case (tapState)
      `TAP_RESET:    next_tapState = tmsS ? `TAP_RESET : `TAP_IDLE;
      `TAP_IDLE:     next_tapState = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_DR:   next_tapState = tmsS ? `TAP_SEL_IR : `TAP_CAP_DR;
      `TAP_CAP_DR:   next_tapState = tmsS ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_SHIFT_DR: next_tapState = tmsS ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_EXIT1_DR: next_tapState = tmsS ? `TAP_UPD_DR : `TAP_PAUSE_DR;
      `TAP_PAUSE_DR: next_tapState = tmsS ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
      `TAP_EXIT2_DR: next_tapState = tmsS ? `TAP_UPD_DR : `TAP_SHIFT_DR;
      `TAP_UPD_DR:   next_tapState = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_IR:   next_tapState = tmsS ? `TAP_RESET : `TAP_CAP_IR;
      `TAP_CAP_IR:   next_tapState = tmsS ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_SHIFT_IR: next_tapState = tmsS ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_EXIT1_IR: next_tapState = tmsS ? `TAP_UPD_IR : `TAP_PAUSE_IR;
      `TAP_PAUSE_IR: next_tapState = tmsS ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
      `TAP_EXIT2_IR: next_tapState = tmsS ? `TAP_UPD_IR : `TAP_SHIFT_IR;
      default:       next_tapState = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
    endcase
  end

  // Capture value of the pin chain, per field
  wire [35:0] pinCapture = {
    ~output_enable_n & flow_select,
    ~output_enable_n & ~flow_select,
    flow_select, output_enable_n,
    b_port_lines, coreBOut, a_port_lines, coreAOut};

  wire isReadOp = (activeInstruction == `OP_READN) | (activeInstruction == `OP_READT);
  wire isSelfChk = activeInstruction == `OP_SELFCHK;

  // Rising-edge work: state advance, capture and shift
  always @(posedge clk) begin
    if (rst) begin
      tapState  <= `TAP_RESET;
      irShift   <= `IR_RESET;
      pinShift  <= `PIN_RESET;
      ctlShift  <= `CTL_RESET;
      bypassBit <= 1'b0;
    end else if (tckRise) begin
      tapState <= next_tapState;
      case (tapState)
        `TAP_RESET: begin
          irShift  <= `IR_RESET;
          pinShift <= `PIN_RESET;
          ctlShift <= `CTL_RESET;
        end
        `TAP_CAP_IR:   irShift <= `IR_CAPTURE;
        `TAP_SHIFT_IR: irShift <= {tdiS, irShift[7:1]};
        `TAP_CAP_DR: begin
          bypassBit <= 1'b0;
          if (selectedChain == `SEL_PINS) begin
            // Read opcodes keep the chain so signatures can be inspected
            if (isSelfChk)
              pinShift <= ~pinShadow;
            else if (!isReadOp)
              pinShift <= pinCapture;
          end
          // Control chain keeps its value here
        end
        `TAP_SHIFT_DR: begin
          bypassBit <= tdiS;
          if (selectedChain == `SEL_PINS)
            pinShift <= {tdiS, pinShift[35:1]};
          else if (selectedChain == `SEL_CTL)
            ctlShift <= {tdiS, ctlShift[10:1]};
        end
        default: begin
          // Exit and Pause states hold the partial scan
        end
      endcase
    end
  end

  wire [3:0] dec = decode(irShift);

  // Falling-edge work: update shadows and drive TDO
  always @(posedge clk) begin
    if (rst) begin
      activeInstruction <= `IR_RESET;
      selectedChain     <= `SEL_BYPASS;
      testMode          <= 1'b0;
      modifiedTestMode  <= 1'b0;
      pinShadow         <= `PIN_RESET;
      ctlShadow         <= `CTL_RESET;
      tdo               <= 1'b0;
      tdoOe_n           <= 1'b1;
    end else if (tckFall) begin
      case (tapState)
        `TAP_RESET: begin
          activeInstruction <= `IR_RESET;
          selectedChain     <= `SEL_BYPASS;
          testMode          <= 1'b0;
          modifiedTestMode  <= 1'b0;
          pinShadow         <= `PIN_RESET;
          ctlShadow         <= `CTL_RESET;
        end
        `TAP_UPD_IR: begin
          activeInstruction <= irShift;
          selectedChain     <= dec[3:2];
          testMode          <= dec[1];
          modifiedTestMode  <= dec[0];
        end
        `TAP_UPD_DR: begin
          if (selectedChain == `SEL_PINS)
            pinShadow <= pinShift;
          else if (selectedChain == `SEL_CTL)
            ctlShadow <= ctlShift;
        end
        default: begin
        end
      endcase
      if (tapState == `TAP_SHIFT_IR) begin
        tdo     <= irShift[0];
        tdoOe_n <= 1'b0;
      end else if (tapState == `TAP_SHIFT_DR) begin
        tdoOe_n <= 1'b0;
        if (selectedChain == `SEL_PINS)
          tdo <= pinShift[0];
        else if (selectedChain == `SEL_CTL)
          tdo <= ctlShift[0];
        else
          tdo <= bypassBit;
      end else begin
        tdoOe_n <= 1'b1;
      end
    end
  end

endmodule // scan_test_port
`default_nettype wire

// ---- testbench/scan_test_port_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "scan_test_defs.vh"
module scan_test_port_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        tck,
  input wire logic        tdo,
  input wire logic        tdoOe_n,
  input wire logic [7:0]  activeInstruction,
  input wire logic [1:0]  selectedChain,
  input wire logic [10:0] ctlShadow,
  input wire logic [3:0]  tapState
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_capToShiftIr;
    tapState == `TAP_CAP_IR ##1 tapState == `TAP_SHIFT_IR;
  endsequence
  property p_resetState;
    $fell(rst) |-> activeInstruction == `IR_RESET && selectedChain == `SEL_BYPASS && tdoOe_n;
  endproperty
  property p_capLoad;
    s_capToShiftIr |-> ##[1:8] (!tdoOe_n && tdo);
  endproperty
  property p_enableInShift;
    $fell(tdoOe_n) |-> !tck && (tapState == `TAP_SHIFT_IR || tapState == `TAP_SHIFT_DR);
  endproperty
  property p_floatAfterExit;
    $rose(tdoOe_n) |-> !tck && (tapState == `TAP_EXIT1_IR || tapState == `TAP_EXIT1_DR);
  endproperty
  property p_pauseHold;
    tapState == `TAP_PAUSE_IR |-> tdoOe_n && $stable(activeInstruction);
  endproperty
  property p_instrUpdate;
    !$stable(activeInstruction) |-> tapState == `TAP_UPD_IR || tapState == `TAP_RESET;
  endproperty
  property p_outOnFall;
    !$stable(tdo) |-> !tck;
  endproperty
  property p_ctlKeep;
    !$stable(ctlShadow) |-> tapState == `TAP_UPD_DR || tapState == `TAP_RESET;
  endproperty
  a_resetState: assert property (p_resetState) else $error("bad state after reset");
  a_capLoad: assert property (p_capLoad) else $error("capture pattern not on tdo");
  a_enableInShift: assert property (p_enableInShift) else $error("tdo enabled late");
  a_floatAfterExit: assert property (p_floatAfterExit) else $error("tdo float wrong");
  a_pauseHold: assert property (p_pauseHold) else $error("pause not idle");
  a_instrUpdate: assert property (p_instrUpdate) else $error("stray instr change");
  a_outOnFall: assert property (p_outOnFall) else $error("tdo moved with tck high");
  a_ctlKeep: assert property (p_ctlKeep) else $error("control shadow changed");
endmodule // scan_test_port_checker
bind scan_test_port scan_test_port_checker i_chk (.clk(clk), .rst(rst), .tck(tck), .tdo(tdo),
  .tdoOe_n(tdoOe_n), .activeInstruction(activeInstruction), .selectedChain(selectedChain),
  .ctlShadow(ctlShadow), .tapState(tapState));
`default_nettype wire

// ---- testbench/jtag_ctl_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module jtag_ctl_model (
  input  wire logic clk,
  input  wire logic tdo,
  input  wire logic tdoOe_n,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One 80 ns TCK period; TDO read just before the rise, floating reads as z
  task automatic tick(input logic m, input logic d, output logic q);
    @(negedge clk);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    q = tdoOe_n ? 1'bz : tdo;
    tck = 1'b1;
    repeat (3) @(negedge clk);
  endtask
endmodule // jtag_ctl_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "scan_test_defs.vh"
module testbench;
  logic        clk, rst, oeN, flow, tck, tms, tdi, tdo, tdoOe_n, testMode, modTest, qb;
  logic [7:0]  aLines, bLines, coreA, coreB, instr;
  logic [1:0]  chain;
  logic [35:0] pinShadow;
  logic [10:0] ctlShadow;
  logic [3:0]  tapState;
  integer      seed, n_fail, total_checks, i;
  logic [7:0]  ops [17] = '{8'h00, 8'h81, 8'h82, 8'h03, 8'h84, 8'h05, 8'h06, 8'h87, 8'h88,
                            8'h09, 8'h0a, 8'h8b, 8'h0c, 8'h8d, 8'h8e, 8'h0f, 8'hff};
  scan_test_port i_scan_test_port (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoOe_n(tdoOe_n), .output_enable_n(oeN), .flow_select(flow),
    .a_port_lines(aLines), .b_port_lines(bLines), .coreAOut(coreA), .coreBOut(coreB),
    .activeInstruction(instr), .selectedChain(chain), .testMode(testMode),
    .modifiedTestMode(modTest), .pinShadow(pinShadow), .ctlShadow(ctlShadow),
    .tapState(tapState));
  jtag_ctl_model i_jtag_ctl_model (.clk(clk), .tdo(tdo), .tdoOe_n(tdoOe_n), .tck(tck),
    .tms(tms), .tdi(tdi));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string what);
    total_checks = total_checks + 1;
    if (ok !== 1'b1) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t(input logic m, input logic d);
    i_jtag_ctl_model.tick(m, d, qb);
  endtask
  // Idle to Idle; pauseAt > 0 parks in Pause-IR (Pause-DR for a data scan) after that many bits, then resumes
  task automatic scan(input logic ir, input int n, input logic [35:0] din, input int pauseAt,
                      output logic [35:0] dout);
    int k;
    dout = '0;
    t(1'b1, 1'b1);
    if (ir) t(1'b1, 1'b1);
    t(1'b0, 1'b1);
    t(1'b0, 1'b1);
    for (k = 0; k < n; k++) begin
      t(k == n - 1 || k == pauseAt - 1, din[k]);
      dout[k] = qb;
      if (k == pauseAt - 1) begin
        repeat (4) t(1'b0, 1'b1);
        chk(tdoOe_n === 1'b1, "tdo driven in pause");
        t(1'b1, 1'b1);
        t(1'b0, 1'b1);
      end
    end
    t(1'b1, 1'b1);
    t(1'b0, 1'b1);
  endtask
  // Expected {chain, test mode, modified test mode} for an opcode
  function automatic logic [3:0] decode(input logic [7:0] op);
    case (op)
      8'h00, 8'h03, 8'h8b: return {`SEL_PINS, 2'b10};
      8'h82, 8'h0a, 8'h0c: return {`SEL_PINS, 2'b00};
      8'h06: return {`SEL_BYPASS, 2'b11};
      8'h87, 8'h09, 8'h8d: return {`SEL_BYPASS, 2'b10};
      8'h8e: return {`SEL_CTL, 2'b00};
      8'h0f: return {`SEL_CTL, 2'b10};
      default: return {`SEL_BYPASS, 2'b00};
    endcase
  endfunction
  function automatic logic [35:0] pinExp();
    return {~oeN & flow, ~oeN & ~flow, flow, oeN, bLines, coreB, aLines, coreA};
  endfunction
  initial begin
    repeat (100000) @(posedge clk);
    n_fail = n_fail + 1;
    print_verdict();
  end
  initial begin
    logic [35:0] d, v;
    logic [7:0]  op;
    logic [3:0]  e, g;
    seed = 91;
    n_fail = 0;
    total_checks = 0;
    rst = 1'b1;
    {oeN, flow, aLines, bLines, coreA, coreB} = '0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t(1'b0, 1'b1);
    chk(instr === 8'hff && chain === `SEL_BYPASS && testMode === 1'b0, "reset instr");
    chk(pinShadow === `PIN_RESET && ctlShadow === `CTL_RESET, "reset chains");
    for (i = 0; i < 23; i++) begin
      op = (i < 17) ? ops[i] : 8'($random(seed));
      if (i >= 17) op[7] = ^op[6:0];
      scan(1'b1, 8, 36'(op), 0, d);
      chk(d[7:0] === `IR_CAPTURE && instr === op, "ir scan");
      e = decode(op);
      g = {chain, testMode, modTest};
      chk(g === e, "decode");
    end
    v = 36'($random(seed));
    // The last random opcode may leave another chain selected, so park on bypass first
    scan(1'b1, 8, 36'(`IR_RESET), 0, d);
    chk(d[7:0] === `IR_CAPTURE && chain === `SEL_BYPASS, "bypass select");
    scan(1'b0, 8, v, 0, d);
    chk(d[7:0] === {v[6:0], 1'b0}, "bypass path");
    scan(1'b1, 8, 36'(`OP_CTLN), 4, d);
    chk(d[7:0] === `IR_CAPTURE && instr === `OP_CTLN, "paused ir scan");
    scan(1'b0, 11, v, 0, d);
    chk(d[10:0] === `CTL_RESET && ctlShadow === v[10:0], "control chain");
    scan(1'b0, 11, ~v, 0, d);
    chk(d[10:0] === v[10:0], "control capture");
    scan(1'b1, 8, 36'(`OP_SAMPLE), 0, d);
    for (i = 0; i < 4; i++) begin
      @(negedge clk);
      {aLines, bLines, coreA, coreB} = $random(seed);
      {flow, oeN} = i[1:0];
      v = {i[3:0] + 4'h1, 32'($random(seed))};
      scan(1'b0, 36, v, 0, d);
      chk(d === pinExp() && pinShadow === v, "pin chain");
    end
    repeat (5) t(1'b1, 1'b1);
    t(1'b0, 1'b1);
    chk(instr === 8'hff && pinShadow === '0 && ctlShadow === `CTL_RESET, "tap reset");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
